//--- src/fc_pkg.sv
// constants, types and register map of the flash command host
// assumes a 50 MHz clock and a parallel flash on plain pins
package fc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_SETUP_NS = 20;
    localparam int T_PULSE_NS = 70;
    localparam int T_HOLD_NS = 20;
    localparam int T_ACC_NS = 120;
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] ACC_CYC =
        4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);

    localparam logic [19:0] CMD_ADDR1 = 20'h05555;
    localparam logic [19:0] CMD_ADDR2 = 20'h02AAA;
    localparam logic [7:0] UNLOCK_D1 = 8'hAA;
    localparam logic [7:0] UNLOCK_D2 = 8'h55;
    localparam logic [7:0] CODE_RESET = 8'hF0;
    localparam logic [7:0] CODE_ID = 8'h90;
    localparam logic [7:0] CODE_PROG = 8'hA0;
    localparam logic [7:0] CODE_ERASE = 8'h80;
    localparam logic [7:0] CODE_CHIP = 8'h10;
    localparam logic [7:0] CODE_SECT = 8'h30;
    localparam logic [7:0] CODE_SUSP = 8'hB0;
    localparam logic [7:0] CODE_RESUME = 8'hD0;
    localparam logic [7:0] CODE_STAT = 8'h70;
    localparam logic [7:0] CODE_CLR = 8'h50;
    localparam logic [7:0] CODE_PSETUP = 8'h60;
    localparam logic [7:0] CODE_PROT = 8'h20;
    localparam logic [7:0] CODE_UNPROT = 8'h40;
    localparam logic [7:0] CODE_ABORT = 8'hE0;
    localparam int SECT_LSB = 15;
    localparam int SECT_MSB = 19;
    localparam logic [4:0] SECT_BOTTOM = 5'h00;
    localparam logic [4:0] SECT_TOP = 5'h1F;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0C;
    localparam logic [7:0] REG_BUF = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_RDATA = 8'h18;
    localparam int CTRL_GO_BIT = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_ERR_BIT = 2;

    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_RESET = 4'h1, OP_ID = 4'h2, OP_PROG = 4'h3,
        OP_CHIP_ERASE = 4'h4, OP_SECT_ERASE = 4'h5, OP_SUSPEND = 4'h6,
        OP_RESUME = 4'h7, OP_STAT_READ = 4'h8, OP_STAT_CLR = 4'h9,
        OP_PROTECT = 4'hA, OP_UNPROTECT = 4'hB, OP_VERIFY = 4'hC, OP_ABORT = 4'hD
    } fc_op_e;
    typedef enum logic [1:0] {CK_END = 2'h0, CK_WRITE = 2'h1, CK_READ = 2'h2, CK_LOAD = 2'h3} fc_kind_e;
    typedef enum logic [1:0] {AS_CMD1 = 2'h0, AS_CMD2 = 2'h1, AS_USER = 2'h2} fc_asel_e;

    typedef struct packed {
        fc_kind_e kind;
        fc_asel_e asel;
        logic [7:0] code;
    } fc_cyc_s;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [19:0] addr;
        logic [31:0] dq_o;
        logic [31:0] dq_oe;
    } fc_pins_s;
endpackage : fc_pkg

//--- src/fc_cycle.sv
// one flash bus cycle: setup, strobe, hold, with read data capture
// assumes dq_i comes straight from the pins, so it is synchronised here
`timescale 1ns/1ns
`default_nettype none
module fc_cycle
    import fc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic is_read,
    input wire logic word_mode,
    input wire logic [19:0] addr,
    input wire logic am1,
    input wire logic [31:0] wdata,
    input wire logic [31:0] dq_i,
    output var fc_pins_s pins,
    output logic [31:0] rdata,
    output logic done
);
    typedef enum logic [3:0] {
        CY_IDLE = 4'b0001, CY_SETUP = 4'b0010, CY_STROBE = 4'b0100, CY_HOLD = 4'b1000
    } fc_cy_e;
    fc_cy_e state, next_state;
    logic [3:0] cnt, next_cnt;
    logic rd_q;
    logic [31:0] dq_s1, dq_s2;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            CY_IDLE: if (start) begin
                next_state = CY_SETUP;
                next_cnt = SETUP_CYC - 4'h1;
            end
            CY_SETUP: if (cnt == 4'h0) begin
                next_state = CY_STROBE;
                next_cnt = rd_q ? ACC_CYC - 4'h1 : PULSE_CYC - 4'h1;
            end else begin
                next_cnt = cnt - 4'h1;
            end
            CY_STROBE: if (cnt == 4'h0) begin
                next_state = CY_HOLD;
                next_cnt = HOLD_CYC - 4'h1;
            end else begin
                next_cnt = cnt - 4'h1;
            end
            CY_HOLD: if (cnt == 4'h0) begin
                next_state = CY_IDLE;
            end else begin
                next_cnt = cnt - 4'h1;
            end
            default: next_state = CY_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= CY_IDLE;
            cnt <= 4'h0;
            rd_q <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            done <= (state == CY_HOLD) && (cnt == 4'h0);
            if (state == CY_IDLE && start) begin
                rd_q <= is_read;
            end
        end
    end

    // address and data held from setup to end of hold
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h0, dq_o: 32'h0, dq_oe: 32'h0};
        end else begin
            pins.ce_n <= (next_state == CY_IDLE);
            pins.we_n <= !(next_state == CY_STROBE && !rd_q);
            pins.oe_n <= !(next_state == CY_STROBE && rd_q);
            if (state == CY_IDLE && start) begin
                pins.addr <= addr;
                pins.dq_o <= word_mode ? {am1, 15'h0, wdata[15:0]} : wdata;
                if (is_read) begin
                    pins.dq_oe <= word_mode ? 32'h80000000 : 32'h0;
                end else begin
                    pins.dq_oe <= word_mode ? 32'h8000FFFF : 32'hFFFFFFFF;
                end
            end else if (next_state == CY_IDLE) begin
                pins.dq_oe <= 32'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dq_s1 <= 32'h0;
            dq_s2 <= 32'h0;
            rdata <= 32'h0;
        end else begin
            dq_s1 <= dq_i;
            dq_s2 <= dq_s1;
            if (state == CY_STROBE && cnt == 4'h0 && rd_q) begin
                rdata <= word_mode ? {16'h0, dq_s2[15:0]} : dq_s2;
            end
        end
    end
endmodule : fc_cycle
`default_nettype wire

//--- src/fc_host.sv
// flash command host: APB register slave that plays command sequences
// and page loads onto a parallel flash through fc_cycle
// assumes software polls the flash's own status by a status read op
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fc_host
    import fc_pkg::*;
#(
    parameter int PAGE_WORDS = 128
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output var fc_pins_s flash,
    input wire logic [31:0] flash_dq_i,
    output logic flash_wide
);
    localparam int IDX_W = $clog2(PAGE_WORDS);
    localparam logic [IDX_W:0] PAGE_MAX = (IDX_W + 1)'(PAGE_WORDS);

    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_ISSUE = 3'b010, ST_WAIT = 3'b100} fc_state_e;
    fc_state_e state;
    fc_op_e op_q;
    logic [2:0] step;
    logic [IDX_W-1:0] ld_idx, wr_ptr;
    logic [IDX_W:0] count;
    logic [20:0] addr_reg;
    logic [31:0] rdata_reg;
    logic done_flag, err_flag;
    logic [31:0] page_buf [PAGE_WORDS];

    logic wr_en, rd_setup, mapped, go_req, go_ok;
    fc_op_e go_op;
    fc_cyc_s cyc;
    logic [20:0] user_w;
    logic [19:0] eng_addr;
    logic eng_am1, eng_start, eng_done;
    logic [31:0] eng_wdata, eng_rdata;
    logic [4:0] req_sect;

    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped = paddr inside {REG_CTRL, REG_CFG, REG_ADDR, REG_COUNT, REG_BUF,
                                  REG_STATUS, REG_RDATA};
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign go_op = fc_op_e'(pwdata[3:0]);
    assign go_req = wr_en && paddr == REG_CTRL && pwdata[CTRL_GO_BIT];
    assign req_sect = flash_wide ? addr_reg[SECT_MSB:SECT_LSB] : addr_reg[SECT_MSB+1:SECT_LSB+1];

    // refuse when busy, unknown op, bad page count or bad protect sector
    always_comb begin
        go_ok = go_req && state == ST_IDLE && pwdata[3:0] <= OP_ABORT;
        if (go_op == OP_PROG && (count == '0 || count > PAGE_MAX)) begin
            go_ok = 1'b0;
        end
        if ((go_op == OP_PROTECT || go_op == OP_UNPROTECT)
            && req_sect != SECT_BOTTOM && req_sect != SECT_TOP) begin
            go_ok = 1'b0;
        end
    end

    function automatic logic [7:0] third_code(input fc_op_e op);
        case (op)
            OP_RESET: third_code = CODE_RESET;
            OP_ID, OP_VERIFY: third_code = CODE_ID;
            OP_PROG: third_code = CODE_PROG;
            OP_CHIP_ERASE, OP_SECT_ERASE: third_code = CODE_ERASE;
            OP_SUSPEND: third_code = CODE_SUSP;
            OP_RESUME: third_code = CODE_RESUME;
            OP_STAT_READ: third_code = CODE_STAT;
            OP_STAT_CLR: third_code = CODE_CLR;
            OP_PROTECT, OP_UNPROTECT: third_code = CODE_PSETUP;
            OP_ABORT: third_code = CODE_ABORT;
            default: third_code = CODE_RESET;
        endcase
    endfunction

    // cycle list of each operation, one step at a time
    function automatic fc_cyc_s seq_step(input fc_op_e op, input logic [2:0] s);
        fc_cyc_s c;
        c = '{kind: CK_END, asel: AS_CMD1, code: 8'h00};
        if (op == OP_READ) begin
            if (s == 3'd0) c = '{kind: CK_READ, asel: AS_USER, code: 8'h00};
        end else begin
            case (s)
                3'd0: c = '{kind: CK_WRITE, asel: AS_CMD1, code: UNLOCK_D1};
                3'd1: c = '{kind: CK_WRITE, asel: AS_CMD2, code: UNLOCK_D2};
                // reset code left as third write
                3'd2: c = '{kind: CK_WRITE, asel: AS_CMD1, code: third_code(op)};
                3'd3: case (op)
                    OP_ID, OP_STAT_READ, OP_VERIFY:
                        c = '{kind: CK_READ, asel: AS_USER, code: 8'h00};
                    OP_PROG: c = '{kind: CK_LOAD, asel: AS_USER, code: 8'h00};
                    OP_CHIP_ERASE, OP_SECT_ERASE, OP_PROTECT, OP_UNPROTECT:
                        c = '{kind: CK_WRITE, asel: AS_CMD1, code: UNLOCK_D1};
                    default: c = '{kind: CK_END, asel: AS_CMD1, code: 8'h00};
                endcase
                3'd4: if (op inside {OP_CHIP_ERASE, OP_SECT_ERASE, OP_PROTECT, OP_UNPROTECT}) begin
                    c = '{kind: CK_WRITE, asel: AS_CMD2, code: UNLOCK_D2};
                end
                3'd5: case (op)
                    OP_CHIP_ERASE: c = '{kind: CK_WRITE, asel: AS_CMD1, code: CODE_CHIP};
                    OP_SECT_ERASE: c = '{kind: CK_WRITE, asel: AS_USER, code: CODE_SECT};
                    OP_PROTECT: c = '{kind: CK_WRITE, asel: AS_USER, code: CODE_PROT};
                    OP_UNPROTECT: c = '{kind: CK_WRITE, asel: AS_USER, code: CODE_UNPROT};
                    default: c = '{kind: CK_END, asel: AS_CMD1, code: 8'h00};
                endcase
                default: c = '{kind: CK_END, asel: AS_CMD1, code: 8'h00};
            endcase
        end
        return c;
    endfunction

    assign cyc = seq_step(op_q, step);
    assign user_w = addr_reg + 21'(ld_idx);

    always_comb begin
        eng_am1 = 1'b0;
        case (cyc.asel)
            AS_CMD1: eng_addr = CMD_ADDR1;
            AS_CMD2: eng_addr = CMD_ADDR2;
            default: begin
                eng_addr = flash_wide ? user_w[19:0] : user_w[20:1];
                eng_am1 = flash_wide ? 1'b0 : user_w[0];
            end
        endcase
        eng_wdata = cyc.kind == CK_LOAD ? page_buf[ld_idx] : {24'h0, cyc.code};
    end
    assign eng_start = state == ST_ISSUE && cyc.kind != CK_END;

    // load is a write pulse with chip selected
    fc_cycle i_fc_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .start(eng_start),
        .is_read(cyc.kind == CK_READ),
        .word_mode(!flash_wide),
        .addr(eng_addr),
        .am1(eng_am1),
        .wdata(eng_wdata),
        .dq_i(flash_dq_i),
        .pins(flash),
        .rdata(eng_rdata),
        .done(eng_done)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            op_q <= OP_READ;
            step <= 3'd0;
            ld_idx <= '0;
        end else begin
            case (state)
                ST_IDLE: if (go_ok) begin
                    op_q <= go_op;
                    step <= 3'd0;
                    ld_idx <= '0;
                    state <= ST_ISSUE;
                end
                ST_ISSUE: state <= cyc.kind == CK_END ? ST_IDLE : ST_WAIT;
                ST_WAIT: if (eng_done) begin
                    state <= ST_ISSUE;
                    if (cyc.kind == CK_LOAD && (IDX_W + 1)'(ld_idx) != count - 1'b1) begin
                        ld_idx <= ld_idx + 1'b1;
                    end else begin
                        step <= step + 3'd1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flash_wide <= 1'b1;
            addr_reg <= 21'h0;
            count <= '0;
            wr_ptr <= '0;
        end else if (wr_en) begin
            case (paddr)
                REG_CFG: flash_wide <= pwdata[0];
                REG_ADDR: addr_reg <= pwdata[20:0];
                REG_COUNT: begin
                    count <= pwdata[IDX_W:0];
                    wr_ptr <= '0;
                end
                REG_BUF: wr_ptr <= wr_ptr + 1'b1;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en && paddr == REG_BUF) begin
            page_buf[wr_ptr] <= pwdata;
        end
    end

    // sticky flags: a setting event wins over the clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_flag <= 1'b0;
            err_flag <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            if (state == ST_ISSUE && cyc.kind == CK_END) begin
                done_flag <= 1'b1;
            end else if (wr_en && paddr == REG_STATUS && pwdata[ST_DONE_BIT]) begin
                done_flag <= 1'b0;
            end
            if (go_req && !go_ok) begin
                err_flag <= 1'b1;
            end else if (wr_en && paddr == REG_STATUS && pwdata[ST_ERR_BIT]) begin
                err_flag <= 1'b0;
            end
            if (state == ST_WAIT && eng_done && cyc.kind == CK_READ) begin
                rdata_reg <= eng_rdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (rd_setup) begin
            case (paddr)
                REG_CTRL: prdata <= {28'h0, op_q};
                REG_CFG: prdata <= {31'h0, flash_wide};
                REG_ADDR: prdata <= {11'h0, addr_reg};
                REG_COUNT: prdata <= 32'(count);
                REG_STATUS: prdata <= {29'h0, err_flag, done_flag, state != ST_IDLE};
                REG_RDATA: prdata <= rdata_reg;
                default: prdata <= 32'h0;
            endcase
        end
    end

    sequence s_first_unlock;
        eng_start && eng_addr == CMD_ADDR1 && eng_wdata[7:0] == UNLOCK_D1;
    endsequence
    sequence s_second_unlock;
        eng_start && eng_addr == CMD_ADDR2 && eng_wdata[7:0] == UNLOCK_D2;
    endsequence

    property p_unlock_pair;
        @(posedge clk) disable iff (!rst_n)
        (eng_start && step == 3'd0 && op_q != OP_READ) |-> s_first_unlock
            ##1 (!eng_start) [*7] ##1 s_second_unlock;
    endproperty
    a_unlock_pair: assert property (p_unlock_pair) else $error("unlock pair wrong");

    property p_erase_tail;
        @(posedge clk) disable iff (!rst_n)
        (eng_start && step == 3'd5 && op_q inside {OP_CHIP_ERASE, OP_SECT_ERASE})
            |-> eng_wdata[7:0] == (op_q == OP_CHIP_ERASE ? CODE_CHIP : CODE_SECT);
    endproperty
    a_erase_tail: assert property (p_erase_tail) else $error("erase code wrong");

    property p_protect_sector;
        @(posedge clk) disable iff (!rst_n)
        (state != ST_IDLE && op_q inside {OP_PROTECT, OP_UNPROTECT})
            |-> req_sect == SECT_BOTTOM || req_sect == SECT_TOP;
    endproperty
    a_protect_sector: assert property (p_protect_sector) else $error("bad protect sector");

    property p_reset_code;
        @(posedge clk) disable iff (!rst_n)
        (eng_start && step == 3'd2 && op_q == OP_RESET) |-> eng_wdata[7:0] == CODE_RESET;
    endproperty
    a_reset_code: assert property (p_reset_code) else $error("reset code wrong");

    property p_load_strobe;
        @(posedge clk) disable iff (!rst_n)
        $fell(flash.we_n) |-> !flash.ce_n && flash.oe_n;
    endproperty
    a_load_strobe: assert property (p_load_strobe) else $error("write strobe misframed");

    property p_load_hold;
        @(posedge clk) disable iff (!rst_n)
        (!flash.we_n && !$past(flash.we_n)) |-> $stable(flash.addr) && $stable(flash.dq_o);
    endproperty
    a_load_hold: assert property (p_load_hold) else $error("pins moved in pulse");

    property p_page_limit;
        @(posedge clk) disable iff (!rst_n)
        (eng_start && cyc.kind == CK_LOAD) |-> (IDX_W + 1)'(ld_idx) < count && count <= PAGE_MAX;
    endproperty
    a_page_limit: assert property (p_page_limit) else $error("page overrun");

    property p_cycle_ends;
        @(posedge clk) disable iff (!rst_n)
        eng_start |-> ##[3:30] eng_done;
    endproperty
    a_cycle_ends: assert property (p_cycle_ends) else $error("bus cycle hung");
endmodule : fc_host
`default_nettype wire

//--- dv/fc_flash_model.sv
// behavioural parallel flash on the far side of the command host
// assumes pins come as the host's struct; operations finish at once
`timescale 1ns/1ns
`default_nettype none
module fc_flash_model
    import fc_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h5A, // arbitrary value
    parameter int LOAD_GAP_NS = 2000
) (
    input wire fc_pins_s pins,
    input wire logic wide,
    output logic [31:0] dq,
    output var int bad_seq = 0
);
    logic [31:0] mem [logic [20:0]];
    logic [31:0] last = 32'h0;
    logic [31:0] rv;
    logic [1:0] prot = 2'b00;
    logic [19:0] lat_a;
    logic [20:0] key;
    logic [7:0] cmd = 8'h00;
    int step = 0;
    int mode = 0;
    time t_load = 0;
    // x16 takes the lowest address bit from the top data pin
    assign key = wide ? {1'b0, pins.addr} : {pins.addr, pins.dq_o[31]};
    task automatic take(input logic [19:0] a, input logic [7:0] d);
        logic ok;
        // unlock pair on the low fifteen lines
        ok = (step == 1 || step == 4) ? (a[14:0] == CMD_ADDR2[14:0] && d == UNLOCK_D2)
            : (step == 0 || step == 3) ? (a[14:0] == CMD_ADDR1[14:0] && d == UNLOCK_D1)
            : step == 2 ? a[14:0] == CMD_ADDR1[14:0] : 1'b1;
        if (!ok) begin
            bad_seq++;
            step = 0;
        end else if (step == 2) begin
            // the code picks the read path or operation
            cmd = d;
            step = 0;
            case (d)
                CODE_RESET: mode = 0;
                CODE_ID: mode = 1;
                CODE_STAT: mode = 2;
                CODE_PROG: begin
                    mode = 3;
                    t_load = $time;
                end
                CODE_ERASE, CODE_PSETUP: step = 3;
                // work ends at once: no busy window, suspend finds no erase
                CODE_CLR, CODE_SUSP, CODE_RESUME, CODE_ABORT: ;
                default: bad_seq++;
            endcase
        end else if (step == 5) begin
            // erase or protect ends the six writes
            step = 0;
            if (cmd == CODE_ERASE && (d == CODE_CHIP || d == CODE_SECT)) begin
                if (d == CODE_CHIP) mem.delete();
                mode = 2;
            end else if (cmd == CODE_PSETUP && (d == CODE_PROT || d == CODE_UNPROT)
                && (a[19:15] == SECT_BOTTOM || a[19:15] == SECT_TOP)) begin
                prot[a[19]] = (d == CODE_PROT);
            end else begin
                bad_seq++;
            end
        end else begin
            step++;
        end
    endtask : take
    always @(negedge pins.we_n) lat_a = pins.addr;
    // data taken on the rising strobe, loads end after a gap
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && mode == 3 && $time - t_load < LOAD_GAP_NS) begin
            mem[key] = wide ? pins.dq_o : {16'h0000, pins.dq_o[15:0]};
            t_load = $time;
        end else if (!pins.ce_n) begin
            take(lat_a, pins.dq_o[7:0]);
        end
    end
    always @(pins or key or mode or prot) begin
        if (mode == 0) begin
            rv = mem.exists(key) ? mem[key] : {11'h0A5, key};
        end else if (mode >= 2) begin
            rv = 32'h80;
        end else if (pins.addr[1]) begin
            // codes by A1 A0 only, verify by sector
            rv = (prot[pins.addr[19]] && (pins.addr[19:15] == SECT_BOTTOM
                || pins.addr[19:15] == SECT_TOP)) ? {24'h0, MAKER_CODE} : 32'h0;
        end else begin
            rv = {24'h0, pins.addr[0] ? PART_CODE : MAKER_CODE};
        end
    end
    // drive only while read-selected, upper half floats in x16
    assign dq = (!pins.ce_n && !pins.oe_n && pins.we_n)
        ? (wide ? rv : {~last[31:16], rv[15:0]}) : ~last;
    always @(posedge pins.oe_n) last = rv;
endmodule : fc_flash_model
`default_nettype wire

//--- dv/fc_host_bench.sv
// self-checking bench of the flash command host with a flash model
// assumes the host answers APB and plays whole sequences per op
`timescale 1ns/1ns
`default_nettype none
module fc_host_bench
    import fc_pkg::*;
;
    localparam logic [7:0] MAKER = 8'h3C;
    localparam logic [7:0] PART = 8'h5A;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, dq, rd;
    logic pready, pslverr, flash_wide, serr;
    fc_pins_s flash;
    int bad_seq;
    int err_count = 0;
    int check_count = 0;
    fc_host i_fc_host(.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash(flash), .flash_dq_i(dq), .flash_wide(flash_wide));
    fc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .LOAD_GAP_NS(400))
        i_fc_flash_model(.pins(flash), .wide(flash_wide), .dq(dq), .bad_seq(bad_seq));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic complete_run();
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_count++;
            complete_run();
        end
    endtask : apb
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : expect_reg
    task automatic run(input logic [3:0] op);
        int n;
        apb(1'b1, REG_CTRL, 32'(op) | (32'h1 << CTRL_GO_BIT));
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[ST_DONE_BIT] !== 1'b1 && n < 100);
        apb(1'b1, REG_STATUS, 32'h2);
        if (n >= 100) begin
            err_count++;
            complete_run();
        end
    endtask : run
    task automatic refuse(input logic [7:0] a, input logic [31:0] v, input logic [3:0] op);
        apb(1'b1, a, v);
        apb(1'b1, REG_CTRL, 32'(op) | (32'h1 << CTRL_GO_BIT));
        expect_reg(REG_STATUS, 32'h4);
        check({31'h0, flash.ce_n}, 32'h1);
        apb(1'b1, REG_STATUS, 32'h4);
    endtask : refuse
    task automatic s_read_id();
        check({31'h0, flash.ce_n}, 32'h1);
        expect_reg(REG_STATUS, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, serr}, 32'h1);
        apb(1'b1, REG_ADDR, 32'h12345);
        run(OP_READ);
        expect_reg(REG_RDATA, {11'h0A5, 21'h12345});
        apb(1'b1, REG_ADDR, 32'h0);
        run(OP_ID);
        expect_reg(REG_RDATA, {24'h0, MAKER});
        apb(1'b1, REG_ADDR, 32'h1);
        run(OP_ID);
        expect_reg(REG_RDATA, {24'h0, PART});
        run(OP_RESET);
        run(OP_READ);
        expect_reg(REG_RDATA, {11'h0A5, 21'h1});
    endtask : s_read_id
    task automatic s_prog_erase();
        apb(1'b1, REG_COUNT, 32'h2);
        apb(1'b1, REG_BUF, 32'hCAFE0001);
        apb(1'b1, REG_BUF, 32'hCAFE0002);
        apb(1'b1, REG_ADDR, 32'h100);
        run(OP_PROG);
        repeat (30) @(posedge clk);
        run(OP_STAT_READ);
        expect_reg(REG_RDATA, 32'h80);
        run(OP_RESET);
        apb(1'b1, REG_ADDR, 32'h101);
        run(OP_READ);
        expect_reg(REG_RDATA, 32'hCAFE0002);
        run(OP_SECT_ERASE);
        run(OP_READ);
        expect_reg(REG_RDATA, 32'h80);
        run(OP_CHIP_ERASE);
        run(OP_RESET);
        run(OP_READ);
        expect_reg(REG_RDATA, {11'h0A5, 21'h101});
    endtask : s_prog_erase
    task automatic s_protect();
        refuse(REG_COUNT, 32'h0, OP_PROG);
        refuse(REG_COUNT, 32'h81, OP_PROG);
        refuse(REG_ADDR, 32'h28000, OP_PROTECT);
        apb(1'b1, REG_ADDR, 32'hF8002);
        run(OP_PROTECT);
        run(OP_VERIFY);
        expect_reg(REG_RDATA, {24'h0, MAKER});
        run(OP_UNPROTECT);
        run(OP_VERIFY);
        expect_reg(REG_RDATA, 32'h0);
        run(OP_SUSPEND);
        run(OP_RESUME);
        run(OP_STAT_CLR);
        run(OP_ABORT);
        run(OP_RESET);
        apb(1'b1, REG_CFG, 32'h0);
        apb(1'b1, REG_ADDR, 32'h0ABCD);
        run(OP_READ);
        check({31'h0, flash_wide}, 32'h0);
        expect_reg(REG_RDATA, 32'h0000ABCD);
        apb(1'b1, REG_CFG, 32'h1);
    endtask : s_protect
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        s_read_id();
        s_prog_erase();
        s_protect();
        check(32'(bad_seq), 32'h0);
        complete_run();
    end
endmodule : fc_host_bench
`default_nettype wire
